// ### adc_pkg.sv
// Constants, register indices and state carriers of the converter control block
package adc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50000000;
  // Internal RC conversion clock period, in ns
  localparam int unsigned RC_TAD_NS = 4000;
  localparam int unsigned RC_TAD_CYC = (RC_TAD_NS * (CLK_HZ / 1000000)) / 1000;
  // Half-CONVERSION_CLOCK_PERIOD lengths in pclk cycles per clock select code
  localparam logic [7:0] HALF_DIV2 = 8'h01;
  localparam logic [7:0] HALF_DIV8 = 8'h04;
  localparam logic [7:0] HALF_DIV32 = 8'h10;
  localparam logic [7:0] HALF_RC = 8'(RC_TAD_CYC / 2);
  // 9.5 CONVERSION_CLOCK_PERIOD is 19 half periods
  localparam logic [4:0] CONV_HALVES = 5'h13;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PORT_A = 8'h05;
  localparam logic [7:0] IDX_PORT_E = 8'h09;
  localparam logic [7:0] IDX_GLOBAL_INT = 8'h0b;
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] IDX_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_E = 8'h89;
  localparam logic [7:0] IDX_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] IDX_ENABLES_TWO = 8'h8d;
  localparam logic [7:0] IDX_PIN_CFG = 8'h9f;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int unsigned DONE_FLAG_BIT = 6;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;
  localparam logic [5:0] DIR_A_RESET = 6'h3f;
  localparam logic [2:0] DIR_E_RESET = 3'h7;
  // Analog pin masks: bit order ra0 ra1 ra2 ra3 ra5 re0 re1 re2
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_PORT_A = 8'h1f;
  localparam logic [7:0] MASK_THREE = 8'h0b;
  localparam logic [7:0] MASK_NONE = 8'h00;

  typedef enum logic {CONV_IDLE, CONV_RUN} conv_e;

  typedef struct packed {
    logic [1:0] clock_sel;
    logic [2:0] channel;
    logic go;
    logic unused;
    logic enable;
  } control_s;

  typedef struct packed {
    conv_e phase;
    control_s ctrl;
    logic [7:0] result;
    logic [7:0] global_int;
    logic [7:0] flags_one;
    logic [7:0] enables_one;
    logic flags_two;
    logic enables_two;
    logic [2:0] pin_cfg;
    logic [5:0] dir_a;
    logic [2:0] dir_e;
    logic psp_mode;
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    logic [8:0] pin_s3;
    logic [8:0] pin_q;
    logic [7:0] div_cnt;
    logic [4:0] half_cnt;
    logic [15:0] conv_cycles;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
    logic timer_clear;
    logic done;
    logic [7:0] analog_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

endpackage

// ### adc_trigger_ctrl.sv
// Converter control: registers, conversion timing, special event trigger
// ****************************************************************
// ****************************************************************
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

module adc_trigger_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_trigger,
  input wire logic [3:0] capture_compare_mode_bits,
  input wire logic [7:0] conversion_sample,
  input wire logic [5:0] port_a_pins,
  input wire logic [2:0] port_e_pins,
  output logic timer_clear,
  output logic converter_enable,
  output logic conversion_active,
  output logic conversion_done,
  output logic [2:0] channel_select,
  output logic [7:0] analog_mask,
  output logic [5:0] port_a_direction,
  output logic [2:0] port_e_direction,
  output logic irq
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Half-CONVERSION_CLOCK_PERIOD length for a clock select code
  function automatic logic [7:0] half_len(input logic [1:0] sel);
    case (sel)
      2'h0: half_len = adc_pkg::HALF_DIV2;
      2'h1: half_len = adc_pkg::HALF_DIV8;
      2'h2: half_len = adc_pkg::HALF_DIV32;
      default: half_len = adc_pkg::HALF_RC;
    endcase
  endfunction

  // Which pins are analog for a pin function select code
  function automatic logic [7:0] pin_mask(input logic [2:0] cfg);
    case (cfg)
      3'h0, 3'h1: pin_mask = adc_pkg::MASK_ALL;
      3'h2, 3'h3: pin_mask = adc_pkg::MASK_PORT_A;
      3'h4, 3'h5: pin_mask = adc_pkg::MASK_THREE;
      default: pin_mask = adc_pkg::MASK_NONE;
    endcase
  endfunction

  adc_pkg::state_s s;
  adc_pkg::state_s n;
  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  logic [7:0] wd;
  logic trig_hit;
  logic tick;
  logic finish;

  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign wd = pwdata[7:0];
  assign trig_hit = event_trigger && (capture_compare_mode_bits == adc_pkg::SPECIAL_EVENT_MODE);
  assign tick = (s.phase == adc_pkg::CONV_RUN) && (s.div_cnt == 8'h00);
  assign finish = tick && (s.half_cnt == adc_pkg::CONV_HALVES - 5'h01);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus writes first, hardware events after, so a hardware set wins
  always_comb
  begin
    n = s;
    n.timer_clear = 1'b0;
    n.done = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
    n.pin_s1 = {port_e_pins, port_a_pins};
    n.pin_s2 = s.pin_s1;
    n.pin_s3 = s.pin_s2;
    n.pin_q = (s.pin_s2 & s.pin_s3) | (s.pin_q & (s.pin_s2 ^ s.pin_s3));

    // Conversion clock divider, counted in half periods
    if (s.phase == adc_pkg::CONV_RUN)
    begin
      n.conv_cycles = s.conv_cycles + 16'h0001;
      if (tick)
      begin
        n.div_cnt = half_len(s.ctrl.clock_sel) - 8'h01;
        n.half_cnt = s.half_cnt + 5'h01;
      end
      else
      begin
        n.div_cnt = s.div_cnt - 8'h01;
      end
    end

    // Register writes at the completing access edge
    if (wr_en)
    begin
      case (idx)
        adc_pkg::IDX_PORT_A: n.pin_q = s.pin_q;
        adc_pkg::IDX_GLOBAL_INT: n.global_int = wd;
        adc_pkg::IDX_FLAGS_ONE: n.flags_one = wd;
        adc_pkg::IDX_FLAGS_TWO: n.flags_two = wd[0];
        adc_pkg::IDX_RESULT: n.result = wd;
        adc_pkg::IDX_CONTROL:
        begin
          n.ctrl = adc_pkg::control_s'(wd);
          n.ctrl.unused = 1'b0;
          // Start only when the converter was already on
          if (!wd[0] || !s.ctrl.enable)
          begin
            n.ctrl.go = 1'b0;
          end
          if (n.ctrl.go && s.phase == adc_pkg::CONV_IDLE)
          begin
            n.phase = adc_pkg::CONV_RUN;
            n.div_cnt = half_len(n.ctrl.clock_sel) - 8'h01;
            n.half_cnt = 5'h00;
            n.conv_cycles = 16'h0001;
          end
          else if (!n.ctrl.go)
          begin
            n.phase = adc_pkg::CONV_IDLE;
          end
        end
        adc_pkg::IDX_IRQ_STATUS: n.irq_status = s.irq_status & ~wd[2:0];
        adc_pkg::IDX_IRQ_MASK: n.irq_mask = wd[2:0];
        adc_pkg::IDX_DIR_A: n.dir_a = wd[5:0];
        adc_pkg::IDX_DIR_E:
        begin
          n.psp_mode = wd[4];
          n.dir_e = wd[2:0];
        end
        adc_pkg::IDX_ENABLES_ONE: n.enables_one = wd;
        adc_pkg::IDX_ENABLES_TWO: n.enables_two = wd[0];
        adc_pkg::IDX_PIN_CFG: n.pin_cfg = wd[2:0];
        default: n.pin_q = n.pin_q;
      endcase
    end
    n.analog_mask = pin_mask(n.pin_cfg);

    // Special event trigger: the timer clears even if the converter is off
    if (trig_hit)
    begin
      n.timer_clear = 1'b1;
      if (n.ctrl.enable && n.phase == adc_pkg::CONV_IDLE)
      begin
        n.ctrl.go = 1'b1;
        n.phase = adc_pkg::CONV_RUN;
        n.div_cnt = half_len(n.ctrl.clock_sel) - 8'h01;
        n.half_cnt = 5'h00;
        n.conv_cycles = 16'h0001;
        n.irq_status[1] = 1'b1;
      end
      else if (!n.ctrl.enable)
      begin
        n.irq_status[2] = 1'b1;
      end
    end

    // Completion: result, flag and busy clear in one edge
    if (finish && s.ctrl.go && n.phase == adc_pkg::CONV_RUN)
    begin
      n.phase = adc_pkg::CONV_IDLE;
      n.ctrl.go = 1'b0;
      n.result = conversion_sample;
      n.flags_one[adc_pkg::DONE_FLAG_BIT] = 1'b1;
      n.irq_status[0] = 1'b1;
      n.done = 1'b1;
    end
    n.irq = |(n.irq_status & n.irq_mask);

    // APB setup cycle: prepare the answer for the access phase
    if (psel && !penable)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      n.pslverr = !addr_ok;
      case (idx)
        adc_pkg::IDX_PORT_A:
          n.prdata[5:0] = {s.pin_q[5] & ~s.analog_mask[4], s.pin_q[4],
                           s.pin_q[3:0] & ~s.analog_mask[3:0]};
        adc_pkg::IDX_PORT_E: n.prdata[2:0] = s.pin_q[8:6] & ~s.analog_mask[7:5];
        adc_pkg::IDX_GLOBAL_INT: n.prdata[7:0] = s.global_int;
        adc_pkg::IDX_FLAGS_ONE: n.prdata[7:0] = s.flags_one;
        adc_pkg::IDX_FLAGS_TWO: n.prdata[0] = s.flags_two;
        adc_pkg::IDX_RESULT: n.prdata[7:0] = s.result;
        adc_pkg::IDX_CONTROL: n.prdata[7:0] = s.ctrl;
        adc_pkg::IDX_IRQ_STATUS: n.prdata[2:0] = s.irq_status;
        adc_pkg::IDX_IRQ_MASK: n.prdata[2:0] = s.irq_mask;
        adc_pkg::IDX_DIR_A: n.prdata[5:0] = s.dir_a;
        adc_pkg::IDX_DIR_E: n.prdata[7:0] = {3'h0, s.psp_mode, 1'b0, s.dir_e};
        adc_pkg::IDX_ENABLES_ONE: n.prdata[7:0] = s.enables_one;
        adc_pkg::IDX_ENABLES_TWO: n.prdata[0] = s.enables_two;
        adc_pkg::IDX_PIN_CFG: n.prdata[2:0] = s.pin_cfg;
        default: n.pslverr = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Any reset kind lands here: converter off, pins analog, inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.dir_a <= adc_pkg::DIR_A_RESET;
      s.dir_e <= adc_pkg::DIR_E_RESET;
      s.analog_mask <= adc_pkg::MASK_ALL;
    end
    else
    begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign timer_clear = s.timer_clear;
  assign converter_enable = s.ctrl.enable;
  assign conversion_active = s.ctrl.go;
  assign conversion_done = s.done;
  assign channel_select = s.ctrl.channel;
  assign analog_mask = s.analog_mask;
  assign port_a_direction = s.dir_a;
  assign port_e_direction = s.dir_e;
  assign irq = s.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_state: assert property ($rose(presetn) |-> s.dir_a == 6'h3f
    && s.analog_mask == 8'hff && !s.ctrl.enable && s.phase == adc_pkg::CONV_IDLE)
    else $error("state after reset wrong");

  a_trig_start: assert property (trig_hit && s.ctrl.enable && !s.ctrl.go && !wr_en
    |=> s.ctrl.go && s.phase == adc_pkg::CONV_RUN && timer_clear)
    else $error("accepted trigger did not start");

  a_trig_ignore: assert property (trig_hit && !s.ctrl.enable && !wr_en
    |=> timer_clear && !s.ctrl.go && $stable(s.phase))
    else $error("disabled trigger mishandled");

  a_mode_gate: assert property (event_trigger && !s.ctrl.go
    && capture_compare_mode_bits != 4'hb && !wr_en |=> !s.ctrl.go && !timer_clear)
    else $error("trigger accepted in wrong mode");

  a_conv_length: assert property (s.done
    |-> $past(s.conv_cycles) == 16'(19 * int'(half_len(s.ctrl.clock_sel))))
    else $error("conversion length wrong");

  // Sampled presetn keeps a reset that lands mid-run from looking like a completion
  a_done_together: assert property (presetn && $fell(s.ctrl.go) && !$past(wr_en)
    |-> s.done && s.flags_one[6] && s.irq_status[0] && s.phase == adc_pkg::CONV_IDLE)
    else $error("completion effects not together");

  a_abort_keep: assert property (wr_en && idx == adc_pkg::IDX_CONTROL && !wd[2]
    && !trig_hit && !finish |=> s.phase == adc_pkg::CONV_IDLE && $stable(s.result))
    else $error("abort changed result");

  a_bit1_zero: assert property (s.pready && !s.pslverr
    && $past(idx) == adc_pkg::IDX_CONTROL |-> s.prdata[1] == 1'b0)
    else $error("control bit 1 reads one");

  a_irq_level: assert property (irq == |(s.irq_status & s.irq_mask))
    else $error("interrupt level wrong");

  // Timer clear comes from an accepted-mode trigger and nothing else
  a_trig_clear: assert property (trig_hit |=> timer_clear)
    else $error("trigger did not clear the timer");

  a_clear_source: assert property (!trig_hit |=> !timer_clear)
    else $error("timer cleared without trigger");

  a_done_pulse: assert property (s.done |=> !s.done)
    else $error("done pulse longer than one cycle");

  // Busy can only stand while the converter is on
  a_busy_enabled: assert property (s.ctrl.go |-> s.ctrl.enable)
    else $error("busy without enable");

  a_busy_phase: assert property (s.ctrl.go == (s.phase == adc_pkg::CONV_RUN))
    else $error("busy bit and phase disagree");

  a_done_result: assert property (s.done |-> s.result == $past(conversion_sample))
    else $error("result not loaded at completion");

  a_flag_set: assert property (finish && s.ctrl.go && !wr_en |=> s.flags_one[6])
    else $error("done flag not set");

  // An abort must neither finish nor touch the done flag
  a_abort_noflag: assert property (wr_en && idx == adc_pkg::IDX_CONTROL && !wd[2]
    |=> !s.done && $stable(s.flags_one[6]))
    else $error("abort reported completion");

  a_mask_decode: assert property (s.analog_mask == pin_mask(s.pin_cfg))
    else $error("analog pin mask wrong");

  // Write one to clear, unless hardware sets the bit again in that cycle
  a_w1c_clear: assert property (wr_en && idx == adc_pkg::IDX_IRQ_STATUS && !trig_hit && !finish
    |=> (s.irq_status & $past(wd[2:0])) == 3'h0)
    else $error("status bit not cleared");

endmodule

// ### adc_trigger_ctrl_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module adc_trigger_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, event_trigger;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, timer_clear, converter_enable, conversion_active, conversion_done, irq;
  logic [3:0] capture_compare_mode_bits;
  logic [7:0] conversion_sample, analog_mask;
  logic [5:0] port_a_pins, port_a_direction;
  logic [2:0] port_e_pins, port_e_direction, channel_select;
  int n_errors = 0;
  int cmp_count = 0;
  // Model of the result register, held across aborts
  logic [7:0] last_result;
  // Expected results, one per trigger accepted in run_conv
  logic [7:0] exp_q[$];

  adc_trigger_ctrl #(.ADDR_W(12)) adc_trigger_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_trigger(event_trigger), .capture_compare_mode_bits(capture_compare_mode_bits),
    .conversion_sample(conversion_sample), .port_a_pins(port_a_pins),
    .port_e_pins(port_e_pins), .timer_clear(timer_clear),
    .converter_enable(converter_enable), .conversion_active(conversion_active),
    .conversion_done(conversion_done), .channel_select(channel_select),
    .analog_mask(analog_mask), .port_a_direction(port_a_direction),
    .port_e_direction(port_e_direction), .irq(irq)
  );

  // ****************************************************************
  // Clock, verdict and bus tasks
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound, samples at that edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'b1, idx, wd, rd, er);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, idx, 8'h00, rd, er);
    `CHK(rd, {24'h0, exp}, "read data")
    `CHK(er, 1'b0, "unexpected slave error")
  endtask

  // Trigger pulse; checks the timer clear and start one cycle on
  task automatic trig(input logic [3:0] m, input logic tc, input logic act);
    @(posedge pclk);
    event_trigger <= 1'b1;
    capture_compare_mode_bits <= m;
    @(posedge pclk);
    event_trigger <= 1'b0;
    #1;
    `CHK(timer_clear, tc, "timer clear")
    `CHK(conversion_active, act, "trigger start")
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Triggered conversion at clock select cs, checks length, result, flag, irq
  task automatic run_conv(input logic [1:0] cs);
    int n, h;
    logic [2:0] ch;
    ch = 3'($urandom % 8);
    conversion_sample <= 8'($urandom);
    h = (cs == 2'd0) ? 1 : (cs == 2'd1) ? 4 : (cs == 2'd2) ? 16 : int'(adc_pkg::HALF_RC);
    wr(adc_pkg::IDX_IRQ_MASK, {7'h0, cs[0]});
    wr(adc_pkg::IDX_CONTROL, {cs, ch, 3'b001});
    `CHK(channel_select, ch, "channel output")
    // Acquisition time on the selected channel before the trigger
    repeat (8) @(posedge pclk);
    trig(adc_pkg::SPECIAL_EVENT_MODE, 1'b1, 1'b1);
    exp_q.push_back(conversion_sample);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (conversion_done !== 1'b1 && n < 4000);
    `CHK(n, 19 * h, "conversion length")
    if (n >= 4000)
      summarize();
    last_result = exp_q.pop_front();
    `CHK(conversion_active, 1'b0, "busy cleared at completion")
    rdchk(adc_pkg::IDX_RESULT, last_result);
    rdchk(adc_pkg::IDX_FLAGS_ONE, 8'h40);
    rdchk(adc_pkg::IDX_CONTROL, {cs, ch, 3'b001});
    rdchk(adc_pkg::IDX_IRQ_STATUS, 8'h03);
    `CHK(irq, cs[0], "masked interrupt level")
    wr(adc_pkg::IDX_IRQ_STATUS, 8'h03);
    `CHK(irq, 1'b0, "interrupt cleared")
    wr(adc_pkg::IDX_FLAGS_ONE, 8'h00);
    $display("test conversion clock select %0d done", cs);
  endtask

  task automatic reset_values;
    `CHK(analog_mask, 8'hff, "pins analog after reset")
    `CHK(port_a_direction, 6'h3f, "port A inputs")
    `CHK(port_e_direction, 3'h7, "port E inputs")
    `CHK(converter_enable, 1'b0, "converter off")
    `CHK(conversion_active, 1'b0, "no conversion")
    rdchk(adc_pkg::IDX_CONTROL, 8'h00);
    rdchk(adc_pkg::IDX_FLAGS_ONE, 8'h00);
    rdchk(adc_pkg::IDX_ENABLES_ONE, 8'h00);
    rdchk(adc_pkg::IDX_DIR_A, 8'h3f);
    rdchk(adc_pkg::IDX_DIR_E, 8'h07);
    rdchk(adc_pkg::IDX_PIN_CFG, 8'h00);
  endtask

  initial
  begin
    logic [31:0] rd;
    logic er;
    logic [5:0] pa;
    {psel, penable, pwrite, event_trigger, paddr, pwdata} = '0;
    capture_compare_mode_bits = 4'h0;
    presetn = 1'b0;
    rd = $urandom(34981);
    conversion_sample = 8'($urandom);
    port_a_pins = 6'($urandom);
    port_e_pins = 3'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    reset_values();
    $display("test reset values done");
    // Bit 1 is unimplemented, enable and channel land in place
    wr(adc_pkg::IDX_CONTROL, 8'hfb);
    `CHK(converter_enable, 1'b1, "enable output")
    rdchk(adc_pkg::IDX_CONTROL, 8'hf9);
    apb(1'b0, 8'h40, 8'h00, rd, er);
    `CHK(er, 1'b1, "unmapped error")
    `CHK(rd, 32'h0, "unmapped read")
    $display("test layout done");
    // Wrong mode is not taken; disabled converter ignores but still clears the timer
    trig(4'ha, 1'b0, 1'b0);
    wr(adc_pkg::IDX_CONTROL, 8'h00);
    trig(adc_pkg::SPECIAL_EVENT_MODE, 1'b1, 1'b0);
    rdchk(adc_pkg::IDX_IRQ_STATUS, 8'h04);
    wr(adc_pkg::IDX_IRQ_STATUS, 8'h04);
    $display("test trigger gating done");
    for (int cs = 0; cs < 4; cs++)
      run_conv(2'(cs));
    // Software start, then abort keeps the old result and sets no flag
    conversion_sample <= ~last_result;
    wr(adc_pkg::IDX_CONTROL, 8'h41);
    wr(adc_pkg::IDX_CONTROL, 8'h45);
    `CHK(conversion_active, 1'b1, "software start")
    wr(adc_pkg::IDX_CONTROL, 8'h41);
    `CHK(conversion_active, 1'b0, "abort")
    repeat (100) @(posedge pclk);
    rdchk(adc_pkg::IDX_RESULT, last_result);
    rdchk(adc_pkg::IDX_FLAGS_ONE, 8'h00);
    $display("test abort done");
    // All pins digital: port A pins read their levels, then port A direction is written
    pa = 6'($urandom);
    port_a_pins <= pa;
    wr(adc_pkg::IDX_PIN_CFG, 8'h06);
    `CHK(analog_mask, 8'h00, "all digital")
    repeat (5) @(posedge pclk);
    rdchk(adc_pkg::IDX_PORT_A, {2'b00, pa});
    wr(adc_pkg::IDX_DIR_A, 8'h00);
    `CHK(port_a_direction, 6'h00, "direction written")
    $display("test pins done");
    // Reset in mid-conversion restores everything
    trig(adc_pkg::SPECIAL_EVENT_MODE, 1'b1, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    reset_values();
    repeat (5) @(posedge pclk);
    rdchk(adc_pkg::IDX_PORT_A, {2'b00, port_a_pins & 6'h10});
    $display("test reset mid-conversion done");
    summarize();
  end
endmodule
